// [card_reader_station_interface.sv]
// card reader controller: station decode, answers, status and interrupts
`timescale 1ns/1ps
`default_nettype none
module card_reader_station_interface (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire card_pkg::chan_req_t req_in,
  output card_pkg::chan_ans_t ans_out,
  output logic [card_pkg::WORD_W-1:0] rd_word_out,
  input wire logic ready_in,
  input wire logic busy_in,
  input wire logic data_ready_in,
  input wire logic alarm_in,
  input wire logic operation_done_in,
  input wire logic [2:0] mask_in,
  output logic [2:0] int_req_out,
  output logic offset_out,
  output logic feed_out,
  input wire logic col_valid_in,
  input wire logic [card_pkg::COL_W-1:0] col_data_in,
  output logic card_done_out,
  output logic card_err_out
);
  typedef struct packed {
    logic [2:0] int_en;
    logic done_flag;
    logic [2:0] int_req;
    logic [card_pkg::WORD_W-1:0] rd_word;
    logic [card_pkg::COL_W-1:0] col_word;
    logic offset;
    logic feed;
  } ctl_state_t;

  ctl_state_t st_reg;
  ctl_state_t st_next;

  function automatic logic [2:0] int_sources(input logic [2:0] en,
                                             input logic done_flag,
                                             input logic data_rdy,
                                             input logic alarm,
                                             input logic [2:0] mask);
    logic [2:0] cond;
    cond = {alarm, done_flag, data_rdy};
    return cond & en & mask;
  endfunction : int_sources

  function automatic logic [card_pkg::WORD_W-1:0] level1(
      input logic [2:0] irq, input logic done_flag, input logic ready,
      input logic busy, input logic data_rdy, input logic alarm);
    logic [card_pkg::WORD_W-1:0] w;
    w = card_pkg::STATUS_RESET;
    w[card_pkg::ST_READY] = ready;
    w[card_pkg::ST_BUSY] = busy;
    w[card_pkg::ST_INT] = |irq;
    w[card_pkg::ST_DATA] = data_rdy;
    w[card_pkg::ST_DONE] = done_flag;
    w[card_pkg::ST_ALARM] = alarm;
    return w;
  endfunction : level1

  logic on_data;
  logic dead_stn;
  logic is_func;
  logic fn_take;
  logic [card_pkg::WORD_W-1:0] fw;

  assign on_data = req_in.station == card_pkg::STN_DATA;
  assign dead_stn = req_in.station == card_pkg::STN_DEAD0 ||
                    req_in.station == card_pkg::STN_DEAD3;
  assign is_func = req_in.kind == card_pkg::REQ_FUNC;
  assign fn_take = req_in.valid & is_func & on_data;
  assign fw = req_in.word;

  // answers are combinational so the channel sees them in the request cycle;
  // stations 0 and 3 stay silent on functions so the channel rejects itself
  always_comb begin
    ans_out.reject = 1'b0;
    ans_out.reply = req_in.valid & (on_data | (dead_stn & ~is_func));
  end

  always_comb begin
    st_next = st_reg;
    st_next.offset = 1'b0;
    st_next.feed = 1'b0;
    // completion sets the flag even when a clear lands in the same cycle
    if (fn_take && fw[card_pkg::FN_CLR_CTL]) begin
      st_next.int_en = 3'h0;
      st_next.done_flag = 1'b0;
    end
    if (fn_take && fw[card_pkg::FN_CLR_INT]) begin
      st_next.int_en = 3'h0;
    end
    if (operation_done_in) begin
      st_next.done_flag = 1'b1;
    end
    // selects act after the clears so one word can clear then arm
    if (fn_take) begin
      if (fw[card_pkg::FN_SEL_DATA]) st_next.int_en[card_pkg::IS_DATA] = 1'b1;
      if (fw[card_pkg::FN_SEL_DONE]) st_next.int_en[card_pkg::IS_DONE] = 1'b1;
      if (fw[card_pkg::FN_SEL_ALARM]) st_next.int_en[card_pkg::IS_ALARM] = 1'b1;
      st_next.offset = fw[card_pkg::FN_OFFSET];
      st_next.feed = fw[card_pkg::FN_FEED];
      // bits above the feed bit are undefined and ignored
    end
    st_next.int_req = int_sources(st_next.int_en, st_next.done_flag,
                                  data_ready_in, alarm_in, mask_in);
    if (col_valid_in) begin
      st_next.col_word = col_data_in;
    end
    if (req_in.valid && !is_func) begin
      if (dead_stn) begin
        st_next.rd_word = card_pkg::STATUS_RESET;
        st_next.rd_word[card_pkg::ST_READY] = ready_in;
      end else if (on_data) begin
        unique case (req_in.kind)
          card_pkg::REQ_STATUS1: st_next.rd_word = level1(st_reg.int_req,
              st_reg.done_flag, ready_in, busy_in, data_ready_in,
              alarm_in);
          card_pkg::REQ_STATUS2: st_next.rd_word = card_pkg::STATUS_RESET;
          card_pkg::REQ_DATA: st_next.rd_word = {4'h0, st_reg.col_word};
          default: st_next.rd_word = st_reg.rd_word;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_word_out = st_reg.rd_word;
  assign int_req_out = st_reg.int_req;
  assign offset_out = st_reg.offset;
  assign feed_out = st_reg.feed;

  card_column_check #(
    .COLS(card_pkg::COLS),
    .COL_W(card_pkg::COL_W)
  ) u_check (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .col_valid_in(col_valid_in),
    .col_data_in(col_data_in),
    .card_done_out(card_done_out),
    .card_err_out(card_err_out)
  );

  property p_stn0_silent;
    @(posedge clk_sys_in) disable iff (rst_in)
    (req_in.valid && is_func && req_in.station == card_pkg::STN_DEAD0)
      |-> !ans_out.reply && !ans_out.reject;
  endproperty
  a_stn0_silent: assert property (p_stn0_silent)
    else $error("station 0 function was answered");

  property p_stn3;
    @(posedge clk_sys_in) disable iff (rst_in)
    (req_in.valid && req_in.station == card_pkg::STN_DEAD3)
      |-> (ans_out.reply == !is_func) && !ans_out.reject;
  endproperty
  a_stn3: assert property (p_stn3)
    else $error("station 3 answer wrong");

  property p_idle_status;
    @(posedge clk_sys_in) disable iff (rst_in)
    (req_in.valid && on_data && req_in.kind == card_pkg::REQ_STATUS1 &&
     st_reg.int_req == 3'h0 && !st_reg.done_flag && ready_in &&
     data_ready_in && !alarm_in && !busy_in)
      |=> rd_word_out == 16'h0009;
  endproperty
  a_idle_status: assert property (p_idle_status)
    else $error("idle status is not Ready and Data");

  property p_clr_ctl;
    @(posedge clk_sys_in) disable iff (rst_in)
    (fn_take && fw[card_pkg::FN_CLR_CTL] && fw[4:2] == 3'h0 &&
     !operation_done_in)
      |-> ans_out.reply ##1 (int_req_out == 3'h0 && !st_reg.done_flag);
  endproperty
  a_clr_ctl: assert property (p_clr_ctl)
    else $error("clear controller left an interrupt");

  property p_clr_int;
    @(posedge clk_sys_in) disable iff (rst_in)
    (fn_take && fw[card_pkg::FN_CLR_INT] && fw[4:2] == 3'h0)
      |-> ans_out.reply ##1 int_req_out == 3'h0;
  endproperty
  a_clr_int: assert property (p_clr_int)
    else $error("clear interrupts left an interrupt");

  property p_data_int;
    @(posedge clk_sys_in) disable iff (rst_in)
    (fn_take && fw[card_pkg::FN_SEL_DATA] && data_ready_in &&
     mask_in[card_pkg::IS_DATA])
      |=> int_req_out[card_pkg::IS_DATA] ##1
          (rd_word_out[card_pkg::ST_INT] || !$past(req_in.valid) ||
           $past(req_in.kind) != card_pkg::REQ_STATUS1 ||
           $past(req_in.station) != card_pkg::STN_DATA);
  endproperty
  a_data_int: assert property (p_data_int)
    else $error("data interrupt not raised");

  property p_done_quiet;
    @(posedge clk_sys_in) disable iff (rst_in)
    (fn_take && fw[card_pkg::FN_CLR_CTL] && !operation_done_in)
      ##1 (!operation_done_in)[*2]
      |-> !int_req_out[card_pkg::IS_DONE];
  endproperty
  a_done_quiet: assert property (p_done_quiet)
    else $error("done interrupt without completion");

  property p_alarm_quiet;
    @(posedge clk_sys_in) disable iff (rst_in)
    (!alarm_in)[*2] |-> !int_req_out[card_pkg::IS_ALARM];
  endproperty
  a_alarm_quiet: assert property (p_alarm_quiet)
    else $error("alarm interrupt without alarm");

  property p_offset_keeps;
    @(posedge clk_sys_in) disable iff (rst_in)
    (fn_take && fw[4:0] == 5'h00 && !operation_done_in)
      |-> ans_out.reply ##1 ($stable(st_reg.int_en) &&
                             $stable(st_reg.done_flag));
  endproperty
  a_offset_keeps: assert property (p_offset_keeps)
    else $error("offset or undefined function changed state");
endmodule : card_reader_station_interface
`default_nettype wire

// [card_pkg.sv]
// shared types and constants for the card reader station interface
`default_nettype none
package card_pkg;
  localparam int WORD_W = 16;
  localparam int STN_W = 3;
  localparam int COL_W = 12;
  localparam int COLS = 80;
  localparam int PAR_COL = 79;
  localparam int CNT_COL = 80;
  localparam logic [STN_W-1:0] STN_DEAD0 = 3'h0;
  localparam logic [STN_W-1:0] STN_DATA = 3'h1;
  localparam logic [STN_W-1:0] STN_DEAD3 = 3'h3;
  // function word bit positions
  localparam int FN_CLR_CTL = 0;
  localparam int FN_CLR_INT = 1;
  localparam int FN_SEL_DATA = 2;
  localparam int FN_SEL_DONE = 3;
  localparam int FN_SEL_ALARM = 4;
  localparam int FN_OFFSET = 5;
  localparam int FN_FEED = 6;
  // level 1 status bit positions
  localparam int ST_READY = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_INT = 2;
  localparam int ST_DATA = 3;
  localparam int ST_DONE = 4;
  localparam int ST_ALARM = 5;
  // interrupt source index
  localparam int IS_DATA = 0;
  localparam int IS_DONE = 1;
  localparam int IS_ALARM = 2;
  localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;

  typedef enum logic [1:0] {
    REQ_FUNC,
    REQ_STATUS1,
    REQ_STATUS2,
    REQ_DATA
  } req_kind_t;

  typedef struct packed {
    logic valid;
    req_kind_t kind;
    logic [STN_W-1:0] station;
    logic [WORD_W-1:0] word;
  } chan_req_t;

  typedef struct packed {
    logic reply;
    logic reject;
  } chan_ans_t;
endpackage : card_pkg
`default_nettype wire

// [card_column_check.sv]
// card column checker: even parity column and hole count column
`timescale 1ns/1ps
`default_nettype none
module card_column_check #(
  parameter int COLS = card_pkg::COLS,
  parameter int COL_W = card_pkg::COL_W
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic col_valid_in,
  input wire logic [COL_W-1:0] col_data_in,
  output logic card_done_out,
  output logic card_err_out
);
  generate
    if (COLS < 3 || COLS > 127 || COL_W < 1 || COL_W > 12) begin : g_bad
      $error("card_column_check: unsupported COLS or COL_W");
    end
  endgenerate

  typedef struct packed {
    logic [6:0] col_cnt;
    logic [COL_W-1:0] par;
    logic [11:0] holes;
    logic err;
    logic done;
  } chk_state_t;

  chk_state_t st_reg;
  chk_state_t st_next;

  function automatic logic [3:0] pop_count(input logic [COL_W-1:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < COL_W; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction : pop_count

  always_comb begin
    logic [6:0] col_no;
    col_no = st_reg.col_cnt + 7'h01;
    st_next = st_reg;
    st_next.done = 1'b0;
    // error must survive the idle gaps between columns, dropped once reported
    st_next.err = st_reg.err & ~st_reg.done;
    if (col_valid_in) begin
      st_next.col_cnt = col_no;
      if (col_no <= 7'(COLS - 2)) begin
        st_next.par = st_reg.par ^ col_data_in;
        st_next.holes = st_reg.holes + {8'h00, pop_count(col_data_in)};
      end else if (col_no == 7'(COLS - 1)) begin
        // parity column makes every row even over the data columns
        st_next.err = st_reg.err | (col_data_in != st_reg.par);
      end else begin
        st_next.done = 1'b1;
        st_next.err = st_reg.err | (col_data_in != st_reg.holes[COL_W-1:0]);
        st_next.col_cnt = 7'h00;
        st_next.par = '0;
        st_next.holes = 12'h000;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign card_done_out = st_reg.done;
  assign card_err_out = st_reg.done & st_reg.err;

  property p_card_done;
    @(posedge clk_sys_in) disable iff (rst_in)
    (col_valid_in && st_reg.col_cnt == 7'(COLS - 1)) |=> card_done_out;
  endproperty
  a_card_done: assert property (p_card_done)
    else $error("card done not raised after last column");
endmodule : card_column_check
`default_nettype wire

// [card_feeder.sv]
// card source: shifted-one columns plus parity and hole count columns
`timescale 1ns/1ps
`default_nettype none
module card_feeder (
  input wire logic clk_sys_in,
  output logic col_valid_out,
  output logic [card_pkg::COL_W-1:0] col_data_out
);
  initial begin
    col_valid_out = 1'b0;
    col_data_out = 12'h5A5;
  end

  // bad flips one parity bit so the card must be flagged
  task automatic send(input logic bad);
    logic [card_pkg::COL_W-1:0] par;
    logic [card_pkg::COL_W-1:0] cnt;
    logic [card_pkg::COL_W-1:0] w;
    par = '0;
    cnt = '0;
    for (int n = 1; n <= card_pkg::COLS; n++) begin
      if (n < card_pkg::PAR_COL) begin
        w = 12'h001 << ((n - 1) % card_pkg::COL_W);
        par ^= w;
        cnt += 12'($countones(w));
      end else if (n == card_pkg::PAR_COL) begin
        w = par ^ {11'h000, bad};
      end else begin
        w = cnt;
      end
      @(posedge clk_sys_in);
      #1;
      col_valid_out = 1'b1;
      col_data_out = w;
      @(posedge clk_sys_in);
      #1;
      col_valid_out = 1'b0;
      // released line: never leave the last word standing
      col_data_out = ~w;
    end
  endtask : send
endmodule : card_feeder
`default_nettype wire

// [tb_card_reader_station_interface.sv]
// testbench for the card reader station interface
`timescale 1ns/1ps
`default_nettype none
module tb_card_reader_station_interface;
  localparam logic [2:0] S0 = card_pkg::STN_DEAD0;
  localparam logic [2:0] S1 = card_pkg::STN_DATA;
  localparam logic [2:0] S3 = card_pkg::STN_DEAD3;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  card_pkg::chan_req_t req = '0;
  card_pkg::chan_ans_t ans;
  logic [15:0] rd_word;
  logic data_rdy = 1'b1;
  logic ready = 1'b1;
  logic busy = 1'b0;
  logic alarm = 1'b0;
  logic op_done = 1'b0;
  logic [2:0] mask = 3'h0;
  logic [2:0] int_req;
  logic offset;
  logic feed;
  logic col_valid;
  logic [11:0] col_data;
  logic card_done;
  logic card_err;
  int miscompares = 0;
  int check_count = 0;

  always #2.5 clk_sys_in = ~clk_sys_in;

  card_reader_station_interface card_reader_station_interface_i (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .req_in(req), .ans_out(ans),
    .rd_word_out(rd_word), .ready_in(ready), .busy_in(busy),
    .data_ready_in(data_rdy), .alarm_in(alarm),
    .operation_done_in(op_done), .mask_in(mask), .int_req_out(int_req),
    .offset_out(offset), .feed_out(feed), .col_valid_in(col_valid),
    .col_data_in(col_data), .card_done_out(card_done),
    .card_err_out(card_err)
  );
  card_feeder card_feeder_i (
    .clk_sys_in(clk_sys_in), .col_valid_out(col_valid),
    .col_data_out(col_data)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic access(input card_pkg::req_kind_t k, input logic [2:0] s,
      input logic [15:0] w, input logic rep);
    @(posedge clk_sys_in);
    #1;
    req = '{valid: 1'b1, kind: k, station: s, word: w};
    #1;
    chk({14'h0000, ans.reply, ans.reject}, {14'h0000, rep, 1'b0});
    @(posedge clk_sys_in);
    #1;
    req.valid = 1'b0;
  endtask : access

  task automatic fn(input logic [2:0] s, input logic [15:0] w,
      input logic rep);
    access(card_pkg::REQ_FUNC, s, w, rep);
  endtask : fn

  task automatic stat(input logic [2:0] s, input logic [15:0] e);
    access(card_pkg::REQ_STATUS1, s, 16'h0000, 1'b1);
    chk(rd_word, e);
  endtask : stat

  task automatic irq(input logic [2:0] e);
    chk({13'h0000, int_req}, {13'h0000, e});
  endtask : irq

  task automatic tick();
    @(posedge clk_sys_in);
    #1;
  endtask : tick

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // a few hundred cycles are expected; this is ample margin
  initial begin
    #20000;
    miscompares++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    stat(S1, 16'h0009);
    access(card_pkg::REQ_STATUS2, S1, 16'h0000, 1'b1);
    chk(rd_word, 16'h0000);
    stat(S0, 16'h0001);
    stat(S3, 16'h0001);
    busy = 1'b1;
    stat(S1, 16'h000B);
    busy = 1'b0;
    ready = 1'b0;
    stat(S3, 16'h0000);
    stat(S1, 16'h0008);
    ready = 1'b1;
    mask = 3'h7;
    fn(S0, 16'h003F, 1'b0);
    fn(S3, 16'h003F, 1'b0);
    irq(3'h0);
    fn(S1, 16'h0004, 1'b1);
    irq(3'h1);
    stat(S1, 16'h000D);
    fn(S1, 16'h0001, 1'b1);
    irq(3'h0);
    stat(S1, 16'h0009);
    fn(S1, 16'h0004, 1'b1);
    fn(S1, 16'h0002, 1'b1);
    irq(3'h0);
    stat(S1, 16'h0009);
    fn(S1, 16'h0008, 1'b1);
    irq(3'h0);
    stat(S1, 16'h0009);
    fn(S1, 16'h0010, 1'b1);
    irq(3'h0);
    stat(S1, 16'h0009);
    fn(S1, 16'h0020, 1'b1);
    chk({15'h0000, offset}, 16'h0001);
    stat(S1, 16'h0009);
    for (int b = 7; b < 16; b++) begin
      fn(S1, 16'h0001 << b, 1'b1);
      irq(3'h0);
      stat(S1, 16'h0009);
    end
    fn(S1, 16'h003F, 1'b1);
    irq(3'h1);
    chk({15'h0000, feed}, 16'h0000);
    stat(S1, 16'h000D);
    fn(S1, 16'h0040, 1'b1);
    chk({15'h0000, feed}, 16'h0001);
    fn(S1, 16'h0001, 1'b1);
    mask = 3'h6;
    fn(S1, 16'h0004, 1'b1);
    irq(3'h0);
    mask = 3'h7;
    tick();
    irq(3'h1);
    fn(S1, 16'h0001, 1'b1);
    op_done = 1'b1;
    tick();
    op_done = 1'b0;
    fn(S1, 16'h0008, 1'b1);
    irq(3'h2);
    fn(S1, 16'h0001, 1'b1);
    irq(3'h0);
    alarm = 1'b1;
    fn(S1, 16'h0010, 1'b1);
    irq(3'h4);
    mask = 3'h3;
    tick();
    irq(3'h0);
    alarm = 1'b0;
    fn(S1, 16'h0001, 1'b1);
    card_feeder_i.send(1'b0);
    chk({14'h0000, card_done, card_err}, 16'h0002);
    card_feeder_i.send(1'b1);
    chk({14'h0000, card_done, card_err}, 16'h0003);
    access(card_pkg::REQ_DATA, S1, 16'h0000, 1'b1);
    chk(rd_word, 16'h004E);
    final_report();
  end
endmodule : tb_card_reader_station_interface
`default_nettype wire
